// [ahpp_pkg.sv]
`default_nettype none
package ahpp_pkg;

   // ==============================================================
   // Widths and clock
   localparam int DATA_W = 16;
   localparam int ADDR_W = 7;
   localparam int CLK_NS = 4;

   // ==============================================================
   // Host port timing in ns and in 250 MHz cycles (least: round up)
   localparam int T_CSL_NS   = 32;
   localparam int T_CSH_NS   = 13;
   localparam int T_CYCLE_NS = 45;
   localparam int T_ACYC_NS  = 45;
   localparam int T_RXINF_NS = 135;
   localparam int CSL_CYC    = (T_CSL_NS + CLK_NS - 1) / CLK_NS;
   localparam int CSH_CYC    = (T_CSH_NS + CLK_NS - 1) / CLK_NS;
   localparam int CYCLE_CYC  = (T_CYCLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACYC_CYC   = (T_ACYC_NS + CLK_NS - 1) / CLK_NS;
   localparam int RXINF_CYC  = (T_RXINF_NS + CLK_NS - 1) / CLK_NS;
   // Each beat held long enough for assertion, cycle and address time
   localparam int HOLD_CYC   = (ACYC_CYC > CSL_CYC) ? ACYC_CYC : CSL_CYC;

   // ==============================================================
   // Address map on A[7:3], and reset values
   localparam logic [4:0]        RXD_BLK      = 5'h00;
   localparam logic [4:0]        RXS_BLK      = 5'h08;
   localparam logic [4:0]        TXS_BLK      = 5'h09;
   localparam logic [ADDR_W-1:0] RX_INFO_ADDR = 7'h3e;
   localparam logic [4:0]        BURST_MAX    = 5'h10;
   localparam logic [DATA_W-1:0] DATA_RST     = 16'h0000;

   typedef enum logic [4:0] {
      SRC_NONE = 5'b00001,
      SRC_CSR  = 5'b00010,
      SRC_RXD  = 5'b00100,
      SRC_RXS  = 5'b01000,
      SRC_TXS  = 5'b10000
   } ahpp_src_t;

   typedef enum logic [3:0] {
      H_IDLE = 4'b0001,
      H_ACT  = 4'b0010,
      H_REL  = 4'b0100,
      H_WAIT = 4'b1000
   } ahpp_hstate_t;

   // ==============================================================
   // Read source decode; direct select skips upper address bits
   function automatic ahpp_src_t ahpp_decode(
      input logic              fsel,
      input logic [ADDR_W-1:0] a
   );
      ahpp_src_t s;
      s = SRC_CSR;
      if (fsel)
         s = SRC_RXD;                                    // RQ11 RQ12
      else if (a[6:2] == RXD_BLK)
         s = SRC_RXD;
      else if (a[6:2] == RXS_BLK)
         s = SRC_RXS;
      else if (a[6:2] == TXS_BLK)
         s = SRC_TXS;
      return s;
   endfunction : ahpp_decode

endpackage : ahpp_pkg
`default_nettype wire

// [ahpp_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface ahpp_if;
   import ahpp_pkg::*;

   logic              host_select_n;
   logic              host_read_strobe_n;
   logic              host_write_strobe_n;
   logic [ADDR_W-1:0] addr;
   logic              rx_fifo_direct_select;
   logic [DATA_W-1:0] host_d_o;
   logic              host_d_oe;
   logic [DATA_W-1:0] dev_d_o;
   logic              dev_d_oe;
   logic [DATA_W-1:0] data;

   // ==============================================================
   // Resolved data bus; undriven bus reads as zero
   assign data = host_d_oe ? host_d_o : (dev_d_oe ? dev_d_o : '0);

   modport dev (
      input  host_select_n, host_read_strobe_n, host_write_strobe_n,
      input  addr, rx_fifo_direct_select, data,
      output dev_d_o, dev_d_oe
   );

   modport host (
      output host_select_n, host_read_strobe_n, host_write_strobe_n,
      output addr, rx_fifo_direct_select, host_d_o, host_d_oe,
      input  data
   );
endinterface : ahpp_if
`default_nettype wire

// [ahpp_dev.sv]
`timescale 1ns/1ns
`default_nettype none
// Contract
// (RQ1) Reads serve CSRs, RX data, RX/TX status
// (RQ2) Counters snapshotted when read cycle starts
// (RQ3) Read needs select and read strobe low
// (RQ4) Host asserts read 32 ns, cycle 45 ns
// (RQ5) Host releases 13 ns between single reads
// (RQ6) Read data valid within 30 ns
// (RQ7) Every transfer carries one 16-bit word
// (RQ8) Burst: one word per address, sixteen max
// (RQ9) Burst data within 40 ns; address 45 ns
// (RQ10) Host releases 13 ns between bursts
// (RQ11) Direct select reads RX data FIFO
// (RQ12) Direct mode keeps A[2:1], ignores A[7:3]; a change on A[7:3] still starts a new beat here
// (RQ13) Direct select timed like an address line
// (RQ14) Direct burst length is unlimited
// (RQ15) Direct burst release held 13 ns
// (RQ16) Single write cycle for every write
// (RQ17) Write needs select and write strobe low
// (RQ18) Host write: 32 ns on, 13 off, 45
// (RQ19) Host waits 135 ns before RX info
// (RQ20) Write data taken at strobe release
// (RQ21) One FIFO pop per completed access
module ahpp_dev
   import ahpp_pkg::*;
(
   input  wire logic              i_ref_clk,  // 250 MHz clock
   input  wire logic              i_rst,      // Async reset, high
   ahpp_if.dev                    bus,        // Host port pins
   output logic                   o_reg_rd,   // CSR read, snapshot
   output logic [ADDR_W-1:0]      o_reg_addr, // CSR read address
   input  wire logic [DATA_W-1:0] i_reg_rdata, // CSR read data
   output logic                   o_rxd_pop,  // RX data FIFO pop
   input  wire logic [DATA_W-1:0] i_rxd_data, // RX data FIFO head
   output logic                   o_rxs_pop,  // RX status FIFO pop
   input  wire logic [DATA_W-1:0] i_rxs_data, // RX status FIFO head
   output logic                   o_txs_pop,  // TX status FIFO pop
   input  wire logic [DATA_W-1:0] i_txs_data, // TX status FIFO head
   output logic                   o_wr_valid, // Write done pulse
   output logic [ADDR_W-1:0]      o_wr_addr,  // Write address
   output logic [DATA_W-1:0]      o_wr_data   // Write data
);

   // ==============================================================
   // Pin sampling
   logic              cs_s;
   logic              rd_s;
   logic              wr_s;
   logic              sel_s;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] din_s;
   logic              rd_act;
   logic              wr_act;

   // Pins are synchronous to the clock; one stage aligns them
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         cs_s   <= 1'b1;
         rd_s   <= 1'b1;
         wr_s   <= 1'b1;
         sel_s  <= 1'b0;
         addr_s <= '0;
         din_s  <= DATA_RST;
      end
      else
      begin
         cs_s   <= bus.host_select_n;                    // RQ20
         rd_s   <= bus.host_read_strobe_n;
         wr_s   <= bus.host_write_strobe_n;
         sel_s  <= bus.rx_fifo_direct_select;            // RQ13
         addr_s <= bus.addr;
         din_s  <= bus.data;                             // RQ7
      end
   end

   // ==============================================================
   // Previous sample, for edge and address-change detection
   logic              rd_act_q;
   logic              wr_act_q;
   logic              sel_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] din_q;

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         rd_act_q <= 1'b0;
         wr_act_q <= 1'b0;
         sel_q    <= 1'b0;
         addr_q   <= '0;
         din_q    <= DATA_RST;
      end
      else
      begin
         rd_act_q <= rd_act;
         wr_act_q <= wr_act;
         sel_q    <= sel_s;
         addr_q   <= addr_s;
         din_q    <= din_s;
      end
   end

   // ==============================================================
   // Read cycle tracking
   logic      rd_start;
   logic      rd_change;
   logic      rd_end;
   logic      pop_ev;
   ahpp_src_t src_now;
   ahpp_src_t src_q;
   logic [4:0] beats_q;
   logic      load_q;
   logic [DATA_W-1:0] dout_reg;

   assign rd_act   = !cs_s && !rd_s;                     // RQ3
   assign wr_act   = !cs_s && !wr_s;                     // RQ17
   assign rd_start = rd_act && !rd_act_q;
   assign rd_end   = !rd_act && rd_act_q;
   // Without direct select, address changes past the burst limit are ignored
   assign rd_change = rd_act && rd_act_q
                   && (addr_s != addr_q || sel_s != sel_q)
                   && (sel_s || beats_q < BURST_MAX);     // RQ8 RQ14
   assign src_now  = ahpp_decode(sel_s, addr_s);         // RQ1 RQ11
   assign pop_ev   = rd_end || rd_change;                // RQ21

   // Pop the source of the access that just finished
   assign o_rxd_pop = pop_ev && src_q == SRC_RXD;        // RQ21
   assign o_rxs_pop = pop_ev && src_q == SRC_RXS;
   assign o_txs_pop = pop_ev && src_q == SRC_TXS;

   // Snapshot strobe lets counters freeze for the whole cycle
   assign o_reg_rd   = (rd_start || rd_change)
                    && src_now == SRC_CSR;               // RQ2
   assign o_reg_addr = addr_s;                           // RQ12

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         src_q <= SRC_NONE;
      else if (rd_start || rd_change)
         src_q <= src_now;
      else if (rd_end)
         src_q <= SRC_NONE;
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         beats_q <= '0;
      else if (rd_start)
         beats_q <= 5'h01;
      else if (rd_change && beats_q < BURST_MAX)
         beats_q <= beats_q + 5'h01;                     // RQ8
   end

   // Load one cycle late so a popped FIFO shows its next head
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         load_q <= 1'b0;
      else
         load_q <= rd_start || rd_change;                // RQ9
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         dout_reg <= DATA_RST;
      else if (load_q)
      begin
         case (src_q)                                    // RQ1 RQ6
            SRC_CSR:  dout_reg <= i_reg_rdata;
            SRC_RXD:  dout_reg <= i_rxd_data;
            SRC_RXS:  dout_reg <= i_rxs_data;
            SRC_TXS:  dout_reg <= i_txs_data;
            default:  dout_reg <= dout_reg;
         endcase
      end
   end

   // Buffer follows the raw strobes so turn-off is immediate
   assign bus.dev_d_oe = !bus.host_select_n
                      && !bus.host_read_strobe_n;        // RQ3
   assign bus.dev_d_o  = dout_reg;

   // ==============================================================
   // Writes: taken at release, from the last sample while active
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_wr_valid <= 1'b0;
         o_wr_addr  <= '0;
         o_wr_data  <= DATA_RST;
      end
      else
      begin
         o_wr_valid <= wr_act_q && !wr_act;              // RQ16 RQ20
         if (wr_act_q && !wr_act)
         begin
            o_wr_addr <= addr_q;
            o_wr_data <= din_q;                          // RQ20
         end
      end
   end

endmodule : ahpp_dev
`default_nettype wire

// [ahpp_host.sv]
`timescale 1ns/1ns
`default_nettype none
module ahpp_fifo #(
   parameter int WIDTH = 29,
   parameter int DEPTH = 16
)(
   input  wire logic             i_ref_clk, // Clock
   input  wire logic             i_rst,     // Async reset, high
   input  wire logic             i_valid,   // Fill side valid
   output logic                  o_ready,   // Fill side ready
   input  wire logic [WIDTH-1:0] i_data,    // Fill side data
   output logic                  o_valid,   // Drain side valid
   input  wire logic             i_ready,   // Drain side ready
   output logic [WIDTH-1:0]      o_data     // Drain side data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wp_reg;
   logic [AW-1:0]    rp_reg;
   logic [AW:0]      cnt_reg;
   logic             push;
   logic             pop;

   assign o_ready = cnt_reg != (AW+1)'(DEPTH);
   assign o_valid = cnt_reg != '0;
   assign o_data  = mem_reg[rp_reg];
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;

   always_ff @(posedge i_ref_clk)
   begin
      if (push)
         mem_reg[wp_reg] <= i_data;
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         wp_reg  <= '0;
         rp_reg  <= '0;
         cnt_reg <= '0;
      end
      else
      begin
         if (push)
            wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
         if (pop)
            rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : ahpp_fifo

module ahpp_host
   import ahpp_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
)(
   input  wire logic              i_ref_clk,   // 250 MHz clock
   input  wire logic              i_rst,       // Async reset, high
   ahpp_if.host                   bus,         // Host port pins
   input  wire logic              i_cmd_valid, // Command valid
   output logic                   o_cmd_ready, // Command queue ready
   input  wire logic              i_cmd_write, // 1 write, 0 read
   input  wire logic              i_cmd_sel,   // Direct RX select
   input  wire logic [ADDR_W-1:0] i_cmd_addr,  // Word address A[7:1]
   input  wire logic [3:0]        i_cmd_len,   // Extra burst beats
   input  wire logic [DATA_W-1:0] i_cmd_wdata, // Write data
   output logic                   o_rsp_valid, // Read word pulse
   output logic [DATA_W-1:0]      o_rsp_data   // Read word
);
   localparam int CW = 2 + ADDR_W + 4 + DATA_W;

   logic              q_valid;
   logic              q_ready;
   logic [CW-1:0]     q_data;
   logic              c_wr;
   logic              c_sel;
   logic [ADDR_W-1:0] c_addr;
   logic [3:0]        c_len;
   logic [DATA_W-1:0] c_wdata;
   logic              info_blk;

   ahpp_fifo #(.WIDTH(CW), .DEPTH(FIFO_DEPTH)) u_cmd_q (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_valid   (i_cmd_valid),
      .o_ready   (o_cmd_ready),
      .i_data    ({i_cmd_write, i_cmd_sel, i_cmd_addr, i_cmd_len,
                   i_cmd_wdata}),
      .o_valid   (q_valid),
      .i_ready   (q_ready),
      .o_data    (q_data)
   );

   assign {c_wr, c_sel, c_addr, c_len, c_wdata} = q_data;

   // ==============================================================
   // Bus sequencer
   ahpp_hstate_t      st_reg;
   logic [3:0]        cnt_reg;
   logic [3:0]        beats_reg;
   logic [5:0]        info_reg;
   logic              rxrd_reg;
   logic              cs_reg;
   logic              rd_reg;
   logic              wr_reg;
   logic              sel_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] dout_reg;

   // Stale RX info reads are avoided by holding them back
   assign info_blk = !c_wr && !c_sel && c_addr == RX_INFO_ADDR
                  && info_reg != '0;                      // RQ19
   assign q_ready  = st_reg == H_IDLE && !info_blk;

   assign bus.host_select_n         = cs_reg;
   assign bus.host_read_strobe_n    = rd_reg;
   assign bus.host_write_strobe_n   = wr_reg;
   assign bus.rx_fifo_direct_select = sel_reg;
   assign bus.addr                  = addr_reg;
   assign bus.host_d_o              = dout_reg;
   assign bus.host_d_oe             = !cs_reg && !wr_reg; // RQ7

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         info_reg <= '0;
      else if (st_reg == H_ACT && cnt_reg == 4'(HOLD_CYC-1)
               && beats_reg == '0 && rxrd_reg)
         info_reg <= 6'(RXINF_CYC);                       // RQ19
      else if (info_reg != '0)
         info_reg <= info_reg - 6'h01;
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         st_reg      <= H_IDLE;
         cnt_reg     <= '0;
         beats_reg   <= '0;
         rxrd_reg    <= 1'b0;
         cs_reg      <= 1'b1;
         rd_reg      <= 1'b1;
         wr_reg      <= 1'b1;
         sel_reg     <= 1'b0;
         addr_reg    <= '0;
         dout_reg    <= DATA_RST;
         o_rsp_valid <= 1'b0;
         o_rsp_data  <= DATA_RST;
      end
      else
      begin
         o_rsp_valid <= 1'b0;
         case (st_reg)
            H_IDLE:
            begin
               if (q_valid && q_ready)
               begin
                  cs_reg    <= 1'b0;
                  rd_reg    <= c_wr;
                  wr_reg    <= !c_wr;                     // RQ16
                  sel_reg   <= c_sel;                     // RQ13
                  addr_reg  <= c_addr;
                  dout_reg  <= c_wdata;
                  beats_reg <= c_wr ? 4'h0 : c_len;       // RQ8
                  rxrd_reg  <= !c_wr
                            && ahpp_decode(c_sel, c_addr) inside
                               {SRC_RXD, SRC_RXS};
                  cnt_reg   <= '0;
                  st_reg    <= H_ACT;
               end
            end
            H_ACT:
            begin
               cnt_reg <= cnt_reg + 4'h1;
               // Each beat held past assertion and address time
               if (cnt_reg == 4'(HOLD_CYC-1))             // RQ4 RQ9 RQ18
               begin
                  cnt_reg <= '0;
                  if (!rd_reg)
                  begin
                     o_rsp_valid <= 1'b1;
                     o_rsp_data  <= bus.data;
                  end
                  if (beats_reg != '0)
                  begin
                     beats_reg <= beats_reg - 4'h1;
                     addr_reg  <= addr_reg + 7'h01;       // RQ8
                  end
                  else
                  begin
                     cs_reg <= 1'b1;
                     rd_reg <= 1'b1;
                     wr_reg <= 1'b1;
                     st_reg <= H_REL;
                  end
               end
            end
            H_REL:
            begin
               cnt_reg <= cnt_reg + 4'h1;
               if (cnt_reg == 4'(CSH_CYC-1))              // RQ5 RQ10 RQ15
               begin
                  cnt_reg <= '0;
                  st_reg  <= H_IDLE;
               end
            end
            default:
               st_reg <= H_IDLE;
         endcase
      end
   end

endmodule : ahpp_host
`default_nettype wire

// [ahpp_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module ahpp_assertions
   import ahpp_pkg::*;
(
   input  wire logic              i_ref_clk,             // Clock
   input  wire logic              i_rst,                 // Async reset
   input  wire logic              host_select_n,         // Select
   input  wire logic              host_read_strobe_n,    // Read strobe
   input  wire logic              host_write_strobe_n,   // Write strobe
   input  wire logic [ADDR_W-1:0] addr,                  // Address
   input  wire logic              rx_fifo_direct_select, // Direct select
   input  wire logic [DATA_W-1:0] host_d_o,              // Host data
   input  wire logic              host_d_oe,             // Host enable
   input  wire logic              dev_d_oe,              // Device enable
   input  wire logic [DATA_W-1:0] dev_d_o                // Device data
);
   logic rd_act;
   logic wr_act;
   assign rd_act = !host_select_n && !host_read_strobe_n;
   assign wr_act = !host_select_n && !host_write_strobe_n;

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);

   // ==============================================================
   // Pin level relations
   property p_dev_oe;
      dev_d_oe == rd_act;
   endproperty
   a_dev_oe: assert property (p_dev_oe)
      else $error("device drives bus outside a read");
   property p_no_clash;
      !(dev_d_oe && host_d_oe);
   endproperty
   a_no_clash: assert property (p_no_clash)
      else $error("both ends drive the data bus");
   property p_wr_oe;
      host_d_oe == wr_act;
   endproperty
   a_wr_oe: assert property (p_wr_oe)
      else $error("host data enable not tied to write cycle");

   // ==============================================================
   // Host timing, in whole cycles of 4 ns
   property p_rd_on;
      $rose(rd_act) |-> rd_act [*8];
   endproperty
   a_rd_on: assert property (p_rd_on)
      else $error("read asserted under 32 ns");
   property p_wr_on;
      $rose(wr_act) |-> wr_act [*8];
   endproperty
   a_wr_on: assert property (p_wr_on)
      else $error("write asserted under 32 ns");
   property p_release;
      $fell(rd_act || wr_act) |-> !(rd_act || wr_act) [*4];
   endproperty
   a_release: assert property (p_release)
      else $error("strobes released under 13 ns");
   property p_addr_hold;
      rd_act && $changed(addr) |=> $stable(addr) [*8];
   endproperty
   a_addr_hold: assert property (p_addr_hold)
      else $error("burst address held too briefly");
   property p_sel_hold;
      rd_act && $past(rd_act) |-> $stable(rx_fifo_direct_select);
   endproperty
   a_sel_hold: assert property (p_sel_hold)
      else $error("direct select moved within a read");
   property p_wr_data;
      wr_act && $past(wr_act) |-> $stable(host_d_o) && $stable(addr);
   endproperty
   a_wr_data: assert property (p_wr_data)
      else $error("write data or address moved within a write");

   // Data may move only early in a beat; later moves miss the host
   property p_rd_data;
      $rose(rd_act) |-> ##7 $stable(dev_d_o) [*5];
   endproperty
   a_rd_data: assert property (p_rd_data)
      else $error("read data settled later than 30 ns");
   property p_burst_data;
      rd_act && $past(rd_act) && $changed(addr)
         |-> ##10 $stable(dev_d_o) [*2];
   endproperty
   a_burst_data: assert property (p_burst_data)
      else $error("burst data settled later than 40 ns");

   c_burst: cover property (rd_act && $past(rd_act) && $changed(addr));
   c_direct: cover property (rd_act && rx_fifo_direct_select);
   c_write: cover property ($fell(wr_act));
endmodule : ahpp_assertions
`default_nettype wire

// [test_async_host_pio_port.sv]
`timescale 1ns/1ns
`default_nettype none
module test_async_host_pio_port;
   import ahpp_pkg::*;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic              cmd_valid = 1'b0;
   logic              cmd_write = 1'b0;
   logic              cmd_sel = 1'b0;
   logic [ADDR_W-1:0] cmd_addr = 7'h00;
   logic [3:0]        cmd_len = 4'h0;
   logic [DATA_W-1:0] cmd_wdata = 16'h0000;
   logic              cmd_ready, rsp_valid, reg_rd, wr_valid;
   logic              rxd_pop, rxs_pop, txs_pop;
   logic [ADDR_W-1:0] reg_addr, wr_addr;
   logic [DATA_W-1:0] rsp_data, wr_data;
   logic [DATA_W-1:0] reg_q = 16'h0000;
   logic [DATA_W-1:0] cnt [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
   logic [DATA_W-1:0] en [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
   logic [DATA_W-1:0] base [4] = '{16'h1000, 16'h5000, 16'h9000, 16'h0000};
   logic [DATA_W-1:0] rq [$];
   logic [22:0]       wq [$];
   logic              saw_full = 1'b0;
   int                errors = 0;
   int                compares = 0;

   always #2 clk = ~clk;

   // ==============================================================
   // Show-ahead sources behind the device; heads move after a pop
   always @(posedge clk)
   begin
      if (rxd_pop) cnt[0] <= cnt[0] + 16'h0001;
      if (rxs_pop) cnt[1] <= cnt[1] + 16'h0001;
      if (txs_pop) cnt[2] <= cnt[2] + 16'h0001;
      if (reg_rd) reg_q <= {9'h155, reg_addr};
   end

   ahpp_if bus_if ();
   ahpp_dev ahpp_dev_inst (
      .i_ref_clk(clk), .i_rst(rst), .bus(bus_if.dev),
      .o_reg_rd(reg_rd), .o_reg_addr(reg_addr), .i_reg_rdata(reg_q),
      .o_rxd_pop(rxd_pop), .i_rxd_data(base[0] + cnt[0]),
      .o_rxs_pop(rxs_pop), .i_rxs_data(base[1] + cnt[1]),
      .o_txs_pop(txs_pop), .i_txs_data(base[2] + cnt[2]),
      .o_wr_valid(wr_valid), .o_wr_addr(wr_addr), .o_wr_data(wr_data));
   // Full 16-word queue; the back-to-back mix still fills it
   ahpp_host #(.FIFO_DEPTH(16)) ahpp_host_inst (
      .i_ref_clk(clk), .i_rst(rst), .bus(bus_if.host),
      .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready),
      .i_cmd_write(cmd_write), .i_cmd_sel(cmd_sel), .i_cmd_addr(cmd_addr),
      .i_cmd_len(cmd_len), .i_cmd_wdata(cmd_wdata),
      .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data));
   ahpp_assertions ahpp_assertions_inst (
      .i_ref_clk(clk), .i_rst(rst),
      .host_select_n(bus_if.host_select_n),
      .host_read_strobe_n(bus_if.host_read_strobe_n),
      .host_write_strobe_n(bus_if.host_write_strobe_n),
      .addr(bus_if.addr), .rx_fifo_direct_select(bus_if.rx_fifo_direct_select),
      .host_d_o(bus_if.host_d_o), .host_d_oe(bus_if.host_d_oe),
      .dev_d_oe(bus_if.dev_d_oe), .dev_d_o(bus_if.dev_d_o));

   // ==============================================================
   // Checking
   task automatic end_sim();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   task automatic check(input logic [22:0] got, input logic [22:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // Next word each source should give, in issue order
   function automatic logic [15:0] expv(input logic s, input logic [6:0] a);
      int k;
      k = (s || a[6:2] == RXD_BLK) ? 0 : (a[6:2] == RXS_BLK) ? 1 :
          (a[6:2] == TXS_BLK) ? 2 : 3;
      expv = (k == 3) ? {9'h155, a} : base[k] + en[k];
      en[k] = en[k] + 16'h0001;
   endfunction : expv

   always @(negedge clk)
   begin
      if (rsp_valid === 1'b1)
         check({7'h00, rsp_data},
               rq.size() ? rq.pop_front() : 23'hx);
      if (wr_valid === 1'b1)
         check({wr_addr, wr_data},
               wq.size() ? wq.pop_front() : 23'hx);
      if (cmd_ready === 1'b0)
         saw_full = 1'b1;
   end

   // ==============================================================
   // Stimulus
   task automatic cmd(input logic w, input logic s, input logic [6:0] a,
                      input logic [3:0] l, input logic [15:0] d);
      logic r;
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_sel <= s;
      cmd_addr <= a;
      cmd_len <= l;
      cmd_wdata <= d;
      repeat (4000)
      begin
         @(negedge clk);
         r = cmd_ready;
         @(posedge clk);
         if (r === 1'b1)
            break;
      end
      if (w)
         wq.push_back({a, d});
      else
         for (int i = 0; i <= l; i++)
            rq.push_back(expv(s, a + 7'(i)));
   endtask : cmd

   initial
   begin
      void'($urandom(12542));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++)
         cmd(1'b1, 1'b0, 7'($urandom), 4'h0, 16'($urandom));
      cmd(1'b0, 1'b0, 7'h01, 4'h0, 16'h0000);
      cmd(1'b0, 1'b0, 7'h20, 4'h0, 16'h0000);
      cmd(1'b0, 1'b0, 7'h24, 4'h0, 16'h0000);
      cmd(1'b0, 1'b0, 7'h10, 4'hf, 16'h0000);
      cmd(1'b0, 1'b1, 7'($urandom), 4'hf, 16'h0000);
      cmd(1'b0, 1'b0, RX_INFO_ADDR, 4'h0, 16'h0000);
      // Back-to-back mix fills the host queue while the pins stall it
      for (int i = 0; i < 10; i++)
      begin
         logic w;
         w = 1'($urandom);
         cmd(w, !w && 1'($urandom), {2'b10, 5'($urandom)}, 4'($urandom),
             16'($urandom));
      end
      cmd_valid <= 1'b0;
      for (int i = 0; i < 4000 && (rq.size() || wq.size()); i++)
         @(posedge clk);
      check({22'h0, saw_full}, 23'h1);
      check(23'(rq.size() + wq.size()), 23'h0);
      end_sim();
   end

   initial
   begin
      #100000;
      errors++;
      end_sim();
   end
endmodule : test_async_host_pio_port
`default_nettype wire
